// ==== logic/port_ef_pkg.sv ====
// shared constants for the port e / port f override block
package port_ef_pkg;
    localparam int PORT_W    = 8;
    // port e bit positions
    localparam int PE_RX     = 0;
    localparam int PE_TX     = 1;
    localparam int PE_XCK    = 2;
    localparam int PE_CMP_N  = 3;
    localparam int PE_SCL    = 4;
    localparam int PE_SDA    = 5;
    localparam int PE_DOUT   = 6;
    localparam int PE_CLKO   = 7;
    // port f bit positions
    localparam int PF_TCK    = 4;
    localparam int PF_TMS    = 5;
    localparam int PF_TDO    = 6;
    localparam int PF_TDI    = 7;
    localparam int ADC_CH_W  = 3;
    // pull-up mask held by the scan interface (bits 7, 5, 4)
    localparam logic [7:0] SCAN_PU_MASK = 8'hB0;
    localparam logic [7:0] ZERO8        = 8'h00;
    localparam logic [7:0] ONES8        = 8'hFF;
    // test controller shift states, one-hot
    typedef enum logic [2:0]
    {
        TAP_OTHER    = 3'b001,
        TAP_SHIFT_IR = 3'b010,
        TAP_SHIFT_DR = 3'b100
    } tap_shift_t;
endpackage

// ==== logic/pin_override_cell.sv ====
// one pin: substitute override values for port-register values
`timescale 1ns/1ps
`default_nettype none
module pin_override_cell
(
    // normal port settings
    input  wire logic pu_i,
    input  wire logic dir_i,
    input  wire logic val_i,
    // overrides
    input  wire logic puoe_i,
    input  wire logic puov_i,
    input  wire logic ddoe_i,
    input  wire logic ddov_i,
    input  wire logic pvoe_i,
    input  wire logic pvov_i,
    input  wire logic dieoe_i,
    input  wire logic dieov_i,
    // resolved pin controls
    output logic      pu_o,
    output logic      dir_o,
    output logic      val_o,
    output logic      die_o
);
    // override wins whenever its enable is set
    always_comb
    begin
        pu_o  = puoe_i  ? puov_i  : pu_i;
        dir_o = ddoe_i  ? ddov_i  : dir_i;
        val_o = pvoe_i  ? pvov_i  : val_i;
        die_o = dieoe_i ? dieov_i : 1'b1;
    end
endmodule
`default_nettype wire

// ==== logic/port_e_f_alternate_override.sv ====
// override logic for port e and port f alternate functions
// Function
// - synchronous transceiver clock on e2 is output when direction_bit_2 set, else input
// - external serial clock on e2 inactive unless transceiver is synchronous
// - receiver enabled forces e0 to input regardless of direction_bit_0
// - forced e0 input pulls up when port_data_bit_0 is one, unless pull-ups disabled
// - transmitter enabled: e1 pull-up off, output, drives transmit data
// - clock-output fuse forces e7 to output driving the io clock
// - two-wire: e5 pull-up off, direction (sda or port5) and dir5, value zero if dir5
// - two-wire: e4 direction (hold or port4) or dir4, value zero if dir4
// - digital input kept on for pin-change enabled pins, and e5/e4 when start interrupt on
// - e3/e2 feed comparator; digital input off when disable set and no pin change
// - scan interface enabled activates f7, f5, f4 pull-ups, held through reset
// - port f bits 7..0 are converter channels; 7..4 also carry scan pins
// - three-wire mode drives e6 with the serial interface data output
// - test data out driven only in shift states, else pulled high
`timescale 1ns/1ps
`default_nettype none
module port_e_f_alternate_override
    import port_ef_pkg::*;
(
    // clock and reset
    input  wire logic              mclk_i,
    input  wire logic              rst_i,
    // port e register bits
    input  wire logic [PORT_W-1:0] port_e_data_i,
    input  wire logic [PORT_W-1:0] port_e_dir_i,
    input  wire logic [PORT_W-1:0] port_e_pin_i,
    // port f register bits
    input  wire logic [PORT_W-1:0] port_f_data_i,
    input  wire logic [PORT_W-1:0] port_f_dir_i,
    input  wire logic [PORT_W-1:0] port_f_pin_i,
    // global controls
    input  wire logic              global_pullup_disable_i,
    input  wire logic              clock_output_fuse_i,
    input  wire logic              io_clock_i,
    // serial transceiver
    input  wire logic              transmitter_enable_i,
    input  wire logic              receiver_enable_i,
    input  wire logic              sync_mode_i,
    input  wire logic              transmit_data_i,
    input  wire logic              serial_external_clock_i,
    // universal serial interface
    input  wire logic              two_wire_mode_i,
    input  wire logic              three_wire_mode_i,
    input  wire logic              clock_hold_i,
    input  wire logic              clock_toggle_strobe_i,
    input  wire logic              start_condition_int_enable_i,
    input  wire logic              serial_iface_data_out_i,
    // pin change and comparator
    input  wire logic [PORT_W-1:0] pin_change_source_i,
    input  wire logic              pin_change_group_enable_i,
    input  wire logic              comparator_neg_input_disable_i,
    input  wire logic              comparator_pos_input_disable_i,
    // scan interface
    input  wire logic              scan_interface_enable_i,
    input  wire logic              scan_data_out_i,
    input  wire logic [2:0]        scan_shift_state_i,
    // port e resolved pin controls
    output logic [PORT_W-1:0]      port_e_pullup_o,
    output logic [PORT_W-1:0]      port_e_out_en_n_o,
    output logic [PORT_W-1:0]      port_e_out_o,
    output logic [PORT_W-1:0]      port_e_din_en_o,
    output logic                   port_e_toggle_o,
    // port f resolved pin controls
    output logic [PORT_W-1:0]      port_f_pullup_o,
    output logic [PORT_W-1:0]      port_f_out_en_n_o,
    output logic [PORT_W-1:0]      port_f_out_o,
    output logic [PORT_W-1:0]      port_f_din_en_o,
    // peripheral inputs taken from pins
    output logic                   serial_iface_data_in_o,
    output logic                   serial_iface_clock_in_o,
    output logic                   serial_rx_data_o,
    output logic                   serial_clock_in_o,
    output logic                   comparator_negative_input_o,
    output logic                   comparator_positive_input_o,
    output logic [PORT_W-1:0]      pin_change_in_o,
    output logic [ADC_CH_W-1:0]    adc_channel_unused_o,
    output logic [PORT_W-1:0]      adc_input_o,
    output logic                   scan_data_in_o,
    output logic                   scan_mode_select_o,
    output logic                   scan_clock_o
);
    // ---------------------------------------------------------------
    // override enable and value vectors
    // ---------------------------------------------------------------
    logic [PORT_W-1:0] e_puoe, e_puov, e_ddoe, e_ddov, e_pvoe, e_pvov, e_dieoe, e_dieov;
    logic [PORT_W-1:0] f_puoe, f_puov, f_ddoe, f_ddov, f_pvoe, f_pvov, f_dieoe, f_dieov;
    logic [PORT_W-1:0] e_pu_norm, f_pu_norm;
    logic [PORT_W-1:0] e_dir, e_val, e_pu, e_die;
    logic [PORT_W-1:0] f_dir, f_val, f_pu, f_die;
    logic              xck_active;
    logic [PORT_W-1:0] pc_en;
    logic              tdo_shift;
    logic              scan_hold_reg;
    logic              scan_hold_next;

    // ---------------------------------------------------------------
    // port e override tables
    // ---------------------------------------------------------------
    always_comb
    begin
        xck_active = transmitter_enable_i & sync_mode_i;
        pc_en      = pin_change_source_i & {PORT_W{pin_change_group_enable_i}};
        e_puoe = ZERO8;
        e_puov = ZERO8;
        e_ddoe = ZERO8;
        e_ddov = ZERO8;
        e_pvoe = ZERO8;
        e_pvov = ZERO8;
        e_dieoe = pc_en;
        e_dieov = ONES8;
        // bit 7: clock output
        e_ddoe[PE_CLKO] = clock_output_fuse_i;
        e_ddov[PE_CLKO] = 1'b1;
        e_pvoe[PE_CLKO] = clock_output_fuse_i;
        e_pvov[PE_CLKO] = io_clock_i;
        // bit 6: three-wire data out
        e_pvoe[PE_DOUT] = three_wire_mode_i;
        e_pvov[PE_DOUT] = serial_iface_data_out_i;
        // bit 5: two-wire data
        e_puoe[PE_SDA] = two_wire_mode_i;
        e_ddoe[PE_SDA] = two_wire_mode_i;
        e_ddov[PE_SDA] = (serial_iface_data_out_i | port_e_data_i[PE_SDA]) & port_e_dir_i[PE_SDA];
        e_pvoe[PE_SDA] = two_wire_mode_i & port_e_dir_i[PE_SDA];
        e_dieoe[PE_SDA] = pc_en[PE_SDA] | start_condition_int_enable_i;
        // bit 4: two-wire clock, combined with the direction bit as an or
        e_ddoe[PE_SCL] = two_wire_mode_i;
        e_ddov[PE_SCL] = clock_hold_i | port_e_data_i[PE_SCL] | port_e_dir_i[PE_SCL];
        e_pvoe[PE_SCL] = two_wire_mode_i & port_e_dir_i[PE_SCL];
        e_dieoe[PE_SCL] = pc_en[PE_SCL] | start_condition_int_enable_i;
        // bit 3 and 2: comparator inputs, digital path gated off
        e_dieoe[PE_CMP_N] = pc_en[PE_CMP_N] | comparator_neg_input_disable_i;
        e_dieov[PE_CMP_N] = pc_en[PE_CMP_N];
        e_dieoe[PE_XCK]   = pc_en[PE_XCK] | comparator_pos_input_disable_i;
        e_dieov[PE_XCK]   = pc_en[PE_XCK];
        // bit 2: external clock out when direction set
        e_pvoe[PE_XCK] = xck_active & port_e_dir_i[PE_XCK];
        e_pvov[PE_XCK] = serial_external_clock_i;
        // bit 1: transmit data
        e_puoe[PE_TX] = transmitter_enable_i;
        e_ddoe[PE_TX] = transmitter_enable_i;
        e_ddov[PE_TX] = 1'b1;
        e_pvoe[PE_TX] = transmitter_enable_i;
        e_pvov[PE_TX] = transmit_data_i;
        // bit 0: receive data, pull-up follows port bit
        e_puoe[PE_RX] = receiver_enable_i;
        e_puov[PE_RX] = port_e_data_i[PE_RX] & ~global_pullup_disable_i;
        e_ddoe[PE_RX] = receiver_enable_i;
        e_ddov[PE_RX] = 1'b0;
    end

    // ---------------------------------------------------------------
    // port f override tables
    // ---------------------------------------------------------------
    always_comb
    begin
        tdo_shift = (scan_shift_state_i == TAP_SHIFT_IR) | (scan_shift_state_i == TAP_SHIFT_DR);
        f_puoe = ZERO8;
        f_puov = ZERO8;
        f_ddoe = ZERO8;
        f_ddov = ZERO8;
        f_pvoe = ZERO8;
        f_pvov = ZERO8;
        f_dieoe = ZERO8;
        f_dieov = ZERO8;
        if (scan_hold_reg)
        begin
            f_puoe[PF_TDI:PF_TCK] = 4'hF;
            f_puov[PF_TDI:PF_TCK] = 4'hF;
            f_ddoe[PF_TDI:PF_TCK] = 4'hF;
            f_dieoe[PF_TDI:PF_TCK] = 4'hF;
            f_ddov[PF_TDO] = tdo_shift;
            f_pvoe[PF_TDO] = 1'b1;
            f_pvov[PF_TDO] = scan_data_out_i;
        end
    end

    // ---------------------------------------------------------------
    // scan enable hold, survives the system reset
    // ---------------------------------------------------------------
    always_comb
    begin
        scan_hold_next = scan_interface_enable_i;
    end

    // not on rst_i: the scan pull-ups must stay through a reset
    always_ff @(posedge mclk_i)
    begin
        scan_hold_reg <= scan_hold_next;
    end

    // ---------------------------------------------------------------
    // per-pin substitution
    // ---------------------------------------------------------------
    assign e_pu_norm = port_e_data_i & ~port_e_dir_i & {PORT_W{~global_pullup_disable_i}};
    assign f_pu_norm = port_f_data_i & ~port_f_dir_i & {PORT_W{~global_pullup_disable_i}};

    genvar g;
    generate
        for (g = 0; g < PORT_W; g++)
        begin : g_pin
            pin_override_cell u_e
            (
                .pu_i    (e_pu_norm[g]),
                .dir_i   (port_e_dir_i[g]),
                .val_i   (port_e_data_i[g]),
                .puoe_i  (e_puoe[g]),
                .puov_i  (e_puov[g]),
                .ddoe_i  (e_ddoe[g]),
                .ddov_i  (e_ddov[g]),
                .pvoe_i  (e_pvoe[g]),
                .pvov_i  (e_pvov[g]),
                .dieoe_i (e_dieoe[g]),
                .dieov_i (e_dieov[g]),
                .pu_o    (e_pu[g]),
                .dir_o   (e_dir[g]),
                .val_o   (e_val[g]),
                .die_o   (e_die[g])
            );
            pin_override_cell u_f
            (
                .pu_i    (f_pu_norm[g]),
                .dir_i   (port_f_dir_i[g]),
                .val_i   (port_f_data_i[g]),
                .puoe_i  (f_puoe[g]),
                .puov_i  (f_puov[g]),
                .ddoe_i  (f_ddoe[g]),
                .ddov_i  (f_ddov[g]),
                .pvoe_i  (f_pvoe[g]),
                .pvov_i  (f_pvov[g]),
                .dieoe_i (f_dieoe[g]),
                .dieov_i (f_dieov[g]),
                .pu_o    (f_pu[g]),
                .dir_o   (f_dir[g]),
                .val_o   (f_val[g]),
                .die_o   (f_die[g])
            );
        end
    endgenerate

    // ---------------------------------------------------------------
    // registered pin controls
    // ---------------------------------------------------------------
    logic [PORT_W-1:0] e_pu_reg, e_oen_reg, e_val_reg, e_die_reg;
    logic [PORT_W-1:0] f_pu_reg, f_oen_reg, f_val_reg, f_die_reg;
    logic [PORT_W-1:0] e_pu_next, e_oen_next, e_val_next, e_die_next;
    logic [PORT_W-1:0] f_pu_next, f_oen_next, f_val_next, f_die_next;
    logic              tdo_drive;

    // tdo pulled high and released outside shift states
    always_comb
    begin
        tdo_drive  = scan_hold_reg & tdo_shift;
        e_pu_next  = e_pu;
        e_oen_next = ~e_dir;
        e_val_next = e_val;
        e_die_next = e_die;
        f_pu_next  = f_pu | (SCAN_PU_MASK & {PORT_W{scan_hold_reg}});
        f_oen_next = ~f_dir;
        f_val_next = f_val;
        f_die_next = f_die;
        if (scan_hold_reg & ~tdo_drive)
        begin
            f_pu_next[PF_TDO] = 1'b1;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            e_pu_reg  <= ZERO8;
            e_oen_reg <= ONES8;
            e_val_reg <= ZERO8;
            e_die_reg <= ONES8;
            f_pu_reg  <= ZERO8;
            f_oen_reg <= ONES8;
            f_val_reg <= ZERO8;
            f_die_reg <= ONES8;
        end
        else
        begin
            e_pu_reg  <= e_pu_next;
            e_oen_reg <= e_oen_next;
            e_val_reg <= e_val_next;
            e_die_reg <= e_die_next;
            f_pu_reg  <= f_pu_next;
            f_oen_reg <= f_oen_next;
            f_val_reg <= f_val_next;
            f_die_reg <= f_die_next;
        end
    end

    // port e pin controls; clock out bypasses the flops to keep io clock intact
    always_comb
    begin
        port_e_pullup_o   = e_pu_reg;
        port_e_out_en_n_o = e_oen_reg;
        port_e_out_o      = e_val_reg;
        port_e_din_en_o   = e_die_reg;
        if (clock_output_fuse_i)
        begin
            port_e_out_en_n_o[PE_CLKO] = 1'b0;
            port_e_out_o[PE_CLKO]      = io_clock_i;
        end
        // scan pull-ups hold through reset
        port_f_pullup_o   = f_pu_reg | (SCAN_PU_MASK & {PORT_W{scan_hold_reg}});
        port_f_out_en_n_o = f_oen_reg;
        port_f_out_o      = f_val_reg;
        port_f_din_en_o   = f_die_reg;
    end

    // ---------------------------------------------------------------
    // peripheral inputs from pins
    // ---------------------------------------------------------------
    assign port_e_toggle_o             = two_wire_mode_i & clock_toggle_strobe_i;
    assign serial_iface_data_in_o      = port_e_pin_i[PE_SDA];
    assign serial_iface_clock_in_o     = port_e_pin_i[PE_SCL];
    assign serial_rx_data_o            = port_e_pin_i[PE_RX];
    assign serial_clock_in_o           = xck_active & ~port_e_dir_i[PE_XCK] & port_e_pin_i[PE_XCK];
    assign comparator_negative_input_o = port_e_pin_i[PE_CMP_N];
    assign comparator_positive_input_o = port_e_pin_i[PE_XCK];
    assign pin_change_in_o             = port_e_pin_i & e_die_reg;
    assign adc_channel_unused_o        = '0;
    assign adc_input_o                 = port_f_pin_i;
    assign scan_data_in_o              = scan_hold_reg & port_f_pin_i[PF_TDI];
    assign scan_mode_select_o          = scan_hold_reg & port_f_pin_i[PF_TMS];
    assign scan_clock_o                = scan_hold_reg & port_f_pin_i[PF_TCK];
endmodule
`default_nettype wire

// ==== tb/port_ef_asserts.sv ====
// concurrent checks on the port e / port f override block
`timescale 1ns/1ps
`default_nettype none
module port_ef_asserts
    import port_ef_pkg::*;
(
    // clock and reset
    input wire logic              mclk_i,
    input wire logic              rst_i,
    // port e settings and pins
    input wire logic [PORT_W-1:0] port_e_data_i,
    input wire logic [PORT_W-1:0] port_e_dir_i,
    input wire logic [PORT_W-1:0] port_e_pin_i,
    // controls
    input wire logic              global_pullup_disable_i,
    input wire logic              clock_output_fuse_i,
    input wire logic              io_clock_i,
    input wire logic              transmitter_enable_i,
    input wire logic              receiver_enable_i,
    input wire logic              sync_mode_i,
    input wire logic              transmit_data_i,
    input wire logic              two_wire_mode_i,
    input wire logic              three_wire_mode_i,
    input wire logic              clock_hold_i,
    input wire logic              serial_iface_data_out_i,
    input wire logic              scan_interface_enable_i,
    // resolved outputs
    input wire logic [PORT_W-1:0] port_e_pullup_o,
    input wire logic [PORT_W-1:0] port_e_out_en_n_o,
    input wire logic [PORT_W-1:0] port_e_out_o,
    input wire logic [PORT_W-1:0] port_f_pullup_o,
    input wire logic              serial_clock_in_o,
    input wire logic              comparator_negative_input_o,
    input wire logic              comparator_positive_input_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);
    // ----
    // serial transceiver pins, tx/rx one edge after the cause; ext clock and clock out checked on the same edge
    // ----
    a_tx_drive: assert property (!$past(rst_i) && $past(transmitter_enable_i) |->
        !port_e_out_en_n_o[PE_TX] && !port_e_pullup_o[PE_TX] && port_e_out_o[PE_TX] == $past(transmit_data_i))
        else $error("tx pin not driving data");
    a_rx_input: assert property (!$past(rst_i) && $past(receiver_enable_i) |->
        port_e_out_en_n_o[PE_RX] && port_e_pullup_o[PE_RX] == ($past(port_e_data_i[PE_RX]) && !$past(global_pullup_disable_i)))
        else $error("rx pin not input");
    a_ext_clk_idle: assert property (!(transmitter_enable_i && sync_mode_i) |-> !serial_clock_in_o)
        else $error("ext clock active when async");
    a_clk_out: assert property (clock_output_fuse_i |->
        !port_e_out_en_n_o[PE_CLKO] && port_e_out_o[PE_CLKO] == io_clock_i)
        else $error("clock out missing");
    // ----
    // serial interface pins
    // ----
    a_sda_zero: assert property (!$past(rst_i) && $past(two_wire_mode_i) && $past(port_e_dir_i[PE_SDA]) |->
        !port_e_out_o[PE_SDA] && !port_e_pullup_o[PE_SDA])
        else $error("sda pin not low");
    a_scl_dir: assert property (!$past(rst_i) && $past(two_wire_mode_i) &&
        ($past(clock_hold_i) || $past(port_e_data_i[PE_SCL]) || $past(port_e_dir_i[PE_SCL])) |->
        !port_e_out_en_n_o[PE_SCL])
        else $error("scl pin not driven");
    a_dout_value: assert property (!$past(rst_i) && $past(three_wire_mode_i) |->
        port_e_out_o[PE_DOUT] == $past(serial_iface_data_out_i))
        else $error("data out not on pin");
    // ----
    // comparator wiring and scan pull-ups
    // ----
    a_cmp_wire: assert property (1'b1 |-> comparator_negative_input_o == port_e_pin_i[PE_CMP_N] &&
        comparator_positive_input_o == port_e_pin_i[PE_XCK])
        else $error("comparator wiring");
    a_scan_pullup: assert property (scan_interface_enable_i [*3] |->
        (port_f_pullup_o & SCAN_PU_MASK) == SCAN_PU_MASK)
        else $error("scan pull-ups off");
endmodule
`default_nettype wire

// ==== tb/peripheral_side.sv ====
// stand-in for the peripherals and software feeding the block
`timescale 1ns/1ps
`default_nettype none
module peripheral_side
(
    // clock and reset
    input  wire logic       mclk_i,
    input  wire logic       rst_i,
    // software side
    input  wire logic       conv_busy_i,
    input  wire logic [7:0] soft_f_data_i,
    // values handed to the block
    output logic            io_clock_o,
    output logic [7:0]      port_f_data_o
);
    logic       io_clock_next;
    logic [7:0] f_data_next;
    // ----
    // divided clock, port f writes held off during conversion
    // ----
    always_comb
    begin
        io_clock_next = ~io_clock_o;
        f_data_next   = conv_busy_i ? port_f_data_o : soft_f_data_i;
    end
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            io_clock_o    <= 1'b0;
            port_f_data_o <= 8'h00;
        end
        else
        begin
            io_clock_o    <= io_clock_next;
            port_f_data_o <= f_data_next;
        end
    end
endmodule
`default_nettype wire

// ==== tb/port_e_f_alternate_override_bench.sv ====
// self-checking bench for the port e / port f override block
`timescale 1ns/1ps
`default_nettype none
module port_e_f_alternate_override_bench
    import port_ef_pkg::*;
;
    // ----
    // stimulus and observed signals
    // ----
    logic            mclk_i = 1'b0;
    logic            rst_i  = 1'b1;
    logic [7:0]      e_data, e_dir, e_pin, f_pin, f_dir, pc_src, soft_f;
    logic            pu_off, fuse, tx_en, rx_en, sync, tx_d, ext_clk, two_w, three_w, hold, tgl, ssie;
    logic            dout, pcie, ndis, pdis, scan_en, scan_out, conv;
    logic [2:0]      tap = TAP_OTHER;
    wire logic [7:0] e_pu, e_oen, e_out, e_din, f_pu, f_oen, f_out, f_din, pc_in, adc_in, f_data;
    wire logic       io_clk, sclk_in, cmp_n, cmp_p, sdi;
    int              bad_count = 0;
    int              n_tests = 0;
    always #25 mclk_i = ~mclk_i;
    peripheral_side ps (.mclk_i(mclk_i), .rst_i(rst_i), .conv_busy_i(conv), .soft_f_data_i(soft_f),
        .io_clock_o(io_clk), .port_f_data_o(f_data));
    port_e_f_alternate_override uut (.mclk_i(mclk_i), .rst_i(rst_i), .port_e_data_i(e_data),
        .port_e_dir_i(e_dir), .port_e_pin_i(e_pin), .port_f_data_i(f_data), .port_f_dir_i(f_dir),
        .port_f_pin_i(f_pin), .global_pullup_disable_i(pu_off), .clock_output_fuse_i(fuse), .io_clock_i(io_clk),
        .transmitter_enable_i(tx_en), .receiver_enable_i(rx_en), .sync_mode_i(sync), .transmit_data_i(tx_d),
        .serial_external_clock_i(ext_clk), .two_wire_mode_i(two_w), .three_wire_mode_i(three_w),
        .clock_hold_i(hold), .clock_toggle_strobe_i(tgl), .start_condition_int_enable_i(ssie),
        .serial_iface_data_out_i(dout), .pin_change_source_i(pc_src), .pin_change_group_enable_i(pcie),
        .comparator_neg_input_disable_i(ndis), .comparator_pos_input_disable_i(pdis),
        .scan_interface_enable_i(scan_en), .scan_data_out_i(scan_out), .scan_shift_state_i(tap),
        .port_e_pullup_o(e_pu), .port_e_out_en_n_o(e_oen), .port_e_out_o(e_out), .port_e_din_en_o(e_din),
        .port_e_toggle_o(), .port_f_pullup_o(f_pu), .port_f_out_en_n_o(f_oen), .port_f_out_o(f_out),
        .port_f_din_en_o(f_din), .serial_iface_data_in_o(), .serial_iface_clock_in_o(), .serial_rx_data_o(),
        .serial_clock_in_o(sclk_in), .comparator_negative_input_o(cmp_n), .comparator_positive_input_o(cmp_p),
        .pin_change_in_o(pc_in), .adc_channel_unused_o(), .adc_input_o(adc_in), .scan_data_in_o(sdi),
        .scan_mode_select_o(), .scan_clock_o());
    // ----
    // shared helpers
    // ----
    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic step(input int n = 1);
        repeat (n) @(posedge mclk_i);
        @(negedge mclk_i);
    endtask
    task automatic drv_e(input logic [7:0] d, input logic [7:0] r);
        e_data = d;
        e_dir  = r;
        step();
    endtask
    task automatic exp_e(input logic [7:0] pu, input logic [7:0] oen, input logic [7:0] out);
        chk("e_pullup", e_pu, pu);
        chk("e_out_en_n", e_oen, oen);
        chk("e_out", e_out, out);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ----
    // scenarios
    // ----
    task automatic t_serial;
        rx_en = 1'b1;
        drv_e(8'h01, 8'h01);
        exp_e(8'h01, 8'hFF, 8'h01);
        pu_off = 1'b1;
        drv_e(8'h01, 8'h01);
        exp_e(8'h00, 8'hFF, 8'h01);
        rx_en = 1'b0;
        drv_e(8'h01, 8'h01);
        exp_e(8'h00, 8'hFE, 8'h01);
        pu_off = 1'b0;
        tx_en  = 1'b1;
        tx_d   = 1'b1;
        drv_e(8'h02, 8'h00);
        exp_e(8'h00, 8'hFD, 8'h02);
        tx_d = 1'b0;
        drv_e(8'h02, 8'h00);
        exp_e(8'h00, 8'hFD, 8'h00);
    endtask
    task automatic t_ext_clock;
        sync    = 1'b1;
        ext_clk = 1'b1;
        drv_e(8'h00, 8'h04);
        exp_e(8'h00, 8'hF9, 8'h04);
        sync = 1'b0;
        drv_e(8'h00, 8'h04);
        exp_e(8'h00, 8'hF9, 8'h00);
        sync = 1'b1;
        e_pin = 8'h04;
        drv_e(8'h00, 8'h00);
        chk("ext_clk_in", {7'h00, sclk_in}, 8'h01);
        sync = 1'b0;
        #1 chk("ext_clk_in", {7'h00, sclk_in}, 8'h00);
        {tx_en, ext_clk} = 2'b00;
    endtask
    task automatic t_clock_out;
        fuse = 1'b1;
        drv_e(8'h00, 8'h00);
        repeat (2)
        begin
            chk("clk_out", {e_oen[7], e_out[7], 6'h00}, {1'b0, io_clk, 6'h00});
            step();
        end
        fuse = 1'b0;
    endtask
    task automatic t_usi;
        two_w = 1'b1;
        drv_e(8'h30, 8'h30);
        exp_e(8'h00, 8'hCF, 8'h00);
        drv_e(8'h30, 8'h00);
        exp_e(8'h10, 8'hEF, 8'h30);
        hold = 1'b1;
        drv_e(8'h00, 8'h00);
        exp_e(8'h00, 8'hEF, 8'h00);
        {two_w, hold, three_w, dout} = 4'b0011;
        drv_e(8'h00, 8'h00);
        exp_e(8'h00, 8'hFF, 8'h40);
        dout = 1'b0;
        drv_e(8'h00, 8'h00);
        exp_e(8'h00, 8'hFF, 8'h00);
        three_w = 1'b0;
    endtask
    task automatic t_din;
        {ndis, pdis, ssie} = 3'b111;
        e_pin = 8'hFF;
        step();
        chk("e_din", e_din, 8'hF3);
        pcie = 1'b1;
        pc_src = 8'h08;
        step();
        chk("e_din", e_din, 8'hFB);
        chk("pc_in", pc_in, 8'hFB);
        e_pin = 8'h08;
        #1 chk("cmp", {6'h00, cmp_n, cmp_p}, 8'h02);
        {ndis, pdis, ssie, pcie} = 4'b0000;
    endtask
    task automatic t_scan;
        scan_en = 1'b1;
        f_pin = 8'h80;
        step(2);
        chk("f_pullup", f_pu, 8'hF0);
        chk("f_out_en_n", f_oen, 8'hFF);
        chk("f_din", f_din, 8'h0F);
        chk("scan_in", {7'h00, sdi}, 8'h01);
        tap = TAP_SHIFT_DR;
        scan_out = 1'b1;
        step();
        chk("f_out_en_n", f_oen, 8'hBF);
        chk("f_out", f_out, 8'h40);
        tap = TAP_SHIFT_IR;
        scan_out = 1'b0;
        step();
        chk("f_out", f_out, 8'h00);
        tap = TAP_OTHER;
        {fuse, rst_i} = 2'b11;
        #1 chk("f_pullup", f_pu & SCAN_PU_MASK, SCAN_PU_MASK);
        chk("e_out_en_n", e_oen, 8'h7F);
        step();
        {fuse, rst_i, scan_en} = 3'b000;
        step(3);
    endtask
    task automatic t_adc;
        f_pin = 8'h5A;
        #1 chk("adc_in", adc_in, 8'h5A);
        conv = 1'b1;
        soft_f = 8'hFF;
        step(2);
        chk("f_out", f_out, 8'h00);
        conv = 1'b0;
        step(2);
        chk("f_out", f_out, 8'hFF);
    endtask
    // ----
    // main sequence and watchdog
    // ----
    initial
    begin
        {e_data, e_dir, e_pin, f_pin, f_dir, pc_src, soft_f} = '0;
        {pu_off, fuse, tx_en, rx_en, sync, tx_d, ext_clk, two_w, three_w, hold, tgl, ssie} = '0;
        {dout, pcie, ndis, pdis, scan_en, scan_out, conv} = '0;
        repeat (6) @(negedge mclk_i);
        exp_e(8'h00, 8'hFF, 8'h00);
        rst_i = 1'b0;
        step();
        t_serial();
        t_ext_clock();
        t_clock_out();
        t_usi();
        t_din();
        t_scan();
        t_adc();
        final_report();
    end
    initial
    begin
        #100000;
        bad_count++;
        final_report();
    end
endmodule
bind port_e_f_alternate_override port_ef_asserts chk_u (.*);
`default_nettype wire
